// >>> hdl/fvc_top.sv
`timescale 1ns/1ps
// Purpose: Function visibility control register and its effective enables
// Assumes: Config dword access with byte enables, write data taken in one cycle
// Notes: Lock freezes every bit; hidden functions must not claim cycles
// How it works
// - 32-bit register at 0x54, resets 0x23DB
// - Trusted-execution lock blocks all writes
// - Bit 13 enables device 6 on variant
// - Bit 9 controls device 3 function 3
// - Function 3 hidden when function 0 off
// - No management engine fuses hide functions 2,3
// - Bit 8 controls device 3 function 2
// - Function 2 hidden when function 0 off
// - Bit 7 controls device 3 function 1
// - Function 1 hidden when function 0 off
// - Bit 6 controls device 3 function 0
module fvc_top
  import fvc_pkg::*;
#(
  parameter bit HAS_PORT6 = 1'b0 // Second graphics port variant
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cfg_wr, // Config write strobe
  input wire logic cfg_rd, // Config read strobe
  input wire logic [7:0] cfg_offset, // Dword aligned config offset
  input wire logic [3:0] cfg_be, // Byte enables
  input wire logic [31:0] cfg_wdata, // Write data
  output logic [31:0] cfg_rdata, // Read data
  output logic cfg_hit, // Register decoded
  input wire logic txt_lock, // Trusted-execution lock
  input wire logic [FVC_FUSE_W-1:0] capability_fuses, // Capability fuses
  input wire logic [3:0] claim_req, // Request per device 3 function
  output logic [3:0] claim_ack, // Function claims the request
  output logic [3:0] endpoint_fn_visible, // Effective function enables
  output logic second_graphics_port_enable // Device 6 effective enable
);
  // Register and read data state
  logic [31:0] function_visibility_control_q;
  logic [31:0] function_visibility_control_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] wr_mask; // Writable bits for this variant
  logic [31:0] be_mask; // Byte lanes selected
  logic sel; // Address decode
  fvc_en_if en ();

  // Variant dependent write mask
  assign wr_mask = HAS_PORT6 ? FVC_WR_MASK_BASE : (FVC_WR_MASK_BASE & ~FVC_BIT13_MASK);
  assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
  assign sel = (cfg_offset == FVC_OFFSET);
  assign cfg_hit = sel & (cfg_wr | cfg_rd);

  // Next register value
  always_comb begin
    function_visibility_control_d = function_visibility_control_q;
    rdata_d = rdata_q;
    if (cfg_wr && sel && !txt_lock) begin
      function_visibility_control_d = (function_visibility_control_q & ~(wr_mask & be_mask))
        | (cfg_wdata & wr_mask & be_mask);
    end
    if (cfg_rd && sel) begin
      rdata_d = function_visibility_control_q;
    end else if (cfg_rd) begin
      // Unmapped offsets read zero
      rdata_d = 32'h00000000;
    end
  end

  // Register storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      function_visibility_control_q <= FVC_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      function_visibility_control_q <= function_visibility_control_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata = rdata_q;

  // Feed the dependency logic
  assign en.fn_stored = function_visibility_control_q[FVC_FN3_BIT:FVC_FN0_BIT];
  // Either fuse means no management engine
  assign en.no_me = capability_fuses[FVC_FUSE_NO_ME_A] | capability_fuses[FVC_FUSE_NO_ME_B];

  fvc_dep u_dep (
    .en(en.dep)
  );

  assign endpoint_fn_visible = en.fn_eff;
  // Device 6 enable on variant only
  assign second_graphics_port_enable = HAS_PORT6 & function_visibility_control_q[FVC_PORT6_BIT];
  assign claim_ack = claim_req & en.fn_eff;

  // Assertions
  reset_value_a: assert property (@(posedge clock) $rose(reset_n) |->
    function_visibility_control_q == FVC_RESET) else $error("bad reset value");
  lock_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
    txt_lock |=> $stable(function_visibility_control_q)) else $error("locked write changed");
  port6_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    second_graphics_port_enable == (HAS_PORT6 && function_visibility_control_q[FVC_PORT6_BIT]))
    else $error("device 6 enable wrong");
  fn3_dep_a: assert property (@(posedge clock) disable iff (!reset_n)
    endpoint_fn_visible[3] |-> (function_visibility_control_q[FVC_FN3_BIT] &&
    function_visibility_control_q[FVC_FN0_BIT])) else $error("function 3 visible wrongly");
  // Function 0 follows only its own bit
  fn0_own_a: assert property (@(posedge clock) disable iff (!reset_n)
    endpoint_fn_visible[0] == function_visibility_control_q[FVC_FN0_BIT])
    else $error("function 0 enable wrong");
  // Read-only bits always hold their reset value
  fixed_bits_a: assert property (@(posedge clock) disable iff (!reset_n)
    (function_visibility_control_q & ~FVC_WR_MASK_BASE) == (FVC_RESET & ~FVC_WR_MASK_BASE))
    else $error("read-only bit changed");
  // Read data reflects the register one cycle after the strobe
  read_data_a: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_rd && sel) |=> cfg_rdata == $past(function_visibility_control_q))
    else $error("read data wrong");
  // Unmapped reads return zero
  unmapped_rd_a: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_rd && !sel) |=> cfg_rdata == 32'h00000000) else $error("unmapped read");
  no_me_a: assert property (@(posedge clock) disable iff (!reset_n)
    en.no_me |-> endpoint_fn_visible[3:2] == 2'b00) else $error("fuse ignored");
  fn2_dep_a: assert property (@(posedge clock) disable iff (!reset_n)
    !function_visibility_control_q[6] |-> !endpoint_fn_visible[2]) else $error("fn2 dep");
  fn1_dep_a: assert property (@(posedge clock) disable iff (!reset_n)
    endpoint_fn_visible[1] == (function_visibility_control_q[7] &&
    function_visibility_control_q[6])) else $error("function 1 enable wrong");
  write_takes_a: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_wr && sel && !txt_lock && cfg_be[0]) |=>
    function_visibility_control_q[6] == $past(cfg_wdata[6])) else $error("fn0 write lost");
  fn3_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_wr && sel && !txt_lock && cfg_be[1]) |=>
    function_visibility_control_q[9:8] == $past(cfg_wdata[9:8])) else $error("fn write");
  fn1_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (cfg_wr && sel && !txt_lock && cfg_be[0]) |=>
    function_visibility_control_q[7] == $past(cfg_wdata[7])) else $error("fn1 write lost");
  claim_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    (claim_ack & ~endpoint_fn_visible) == 4'h0) else $error("hidden claim");
  reserved_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    function_visibility_control_q[31:15] == 17'h00000) else $error("reserved set");

  locked_write_c: cover property (@(posedge clock) disable iff (!reset_n) cfg_wr && sel && txt_lock);
  fn0_off_c: cover property (@(posedge clock) disable iff (!reset_n) !endpoint_fn_visible[0]);
  fuse_hide_c: cover property (@(posedge clock) disable iff (!reset_n)
    en.no_me && function_visibility_control_q[9]);
  read_c: cover property (@(posedge clock) disable iff (!reset_n) cfg_rd && sel);
endmodule

// >>> hdl/fvc_pkg.sv
// Purpose: Constants for the function visibility control register block
// Assumes: One 32-bit configuration register, accessed as a dword
// Notes: Bits 6 to 0 other than endpoint function 0 are plain storage here
package fvc_pkg;
  // Configuration address of the register (bus 0, device 0, function 0)
  localparam logic [7:0] FVC_OFFSET = 8'h54;
  localparam logic [31:0] FVC_RESET = 32'h000023DB;
  // Bits that software may change (14, 13, 9:6, 4, 3, 1)
  localparam logic [31:0] FVC_WR_MASK_BASE = 32'h000063DA;
  // Bit 13 is writable only on the second graphics port variant
  localparam logic [31:0] FVC_BIT13_MASK = 32'h00002000;
  // Field positions
  localparam int FVC_FN0_BIT = 6;
  localparam int FVC_FN1_BIT = 7;
  localparam int FVC_FN2_BIT = 8;
  localparam int FVC_FN3_BIT = 9;
  localparam int FVC_PORT6_BIT = 13;
  // Capability fuse positions for management engine absence
  localparam int FVC_FUSE_NO_ME_A = 56;
  localparam int FVC_FUSE_NO_ME_B = 57;
  localparam int FVC_FUSE_W = 64;
  // Number of endpoint functions on device 3
  localparam int FVC_NUM_FN = 4;
endpackage

// >>> hdl/fvc_en_if.sv
`timescale 1ns/1ps
// Purpose: Carries stored enables and effective enables between modules
// Assumes: Single clock domain
// Notes: Pure wires, no state
interface fvc_en_if;
  import fvc_pkg::*;
  logic [FVC_NUM_FN-1:0] fn_stored; // Stored endpoint function enables
  logic no_me; // Management engine capability absent
  logic [FVC_NUM_FN-1:0] fn_eff; // Effective endpoint function enables
  modport src (output fn_stored, output no_me, input fn_eff);
  modport dep (input fn_stored, input no_me, output fn_eff);
endinterface

// >>> hdl/fvc_dep.sv
`timescale 1ns/1ps
// Purpose: Works out effective enables of device 3 functions
// Assumes: Inputs come from registers
// Notes: Combinational only
module fvc_dep
  import fvc_pkg::*;
(
  fvc_en_if.dep en
);
  // Per function dependency on function 0 and on fuses
  genvar gi;
  generate
    for (gi = 0; gi < FVC_NUM_FN; gi++) begin : g_fn
      if (gi == 0) begin : g_f0
        assign en.fn_eff[gi] = en.fn_stored[gi];
      end else if (gi == 1) begin : g_f1
        assign en.fn_eff[gi] = en.fn_stored[gi] & en.fn_stored[0];
      end else begin : g_f23
        // Need function 0; need management engine
        assign en.fn_eff[gi] = en.fn_stored[gi] & en.fn_stored[0] & ~en.no_me;
      end
    end
  endgenerate
endmodule

// >>> tb/fvc_top_tb.sv
// Purpose: Self-checking bench for the function visibility control register
// Assumes: Second graphics port variant, so bit 13 is writable
// Notes: Inputs change at the falling edge; a local model predicts every read
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module fvc_top_tb;
  import fvc_pkg::*;
  logic clock, reset_n, cfg_wr, cfg_rd, cfg_hit, txt_lock, port6;
  logic [7:0] cfg_offset;
  logic [3:0] cfg_be, claim_req, claim_ack, vis_o;
  logic [31:0] cfg_wdata, cfg_rdata, model;
  logic [FVC_FUSE_W-1:0] capability_fuses;
  int err_count, checks_done, cyc;
  fvc_top #(.HAS_PORT6(1'b1)) dut_u (.clock(clock), .reset_n(reset_n), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_offset(cfg_offset), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .txt_lock(txt_lock),
    .capability_fuses(capability_fuses), .claim_req(claim_req), .claim_ack(claim_ack),
    .endpoint_fn_visible(vis_o), .second_graphics_port_enable(port6));
  // Clock of 100 ns period
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // Expected effective enables, fn3..fn0
  function automatic logic [3:0] vis(logic [31:0] r, logic nm);
    vis = {r[9] & r[6] & ~nm, r[8] & r[6] & ~nm, r[7] & r[6], r[6]};
  endfunction
  // Write one dword and update the model
  task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
    logic [31:0] m;
    m = FVC_WR_MASK_BASE & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    @(negedge clock) {cfg_wr, cfg_offset, cfg_be, cfg_wdata} = {1'b1, off, be, d};
    @(negedge clock) cfg_wr = 0;
    if (!txt_lock && off == FVC_OFFSET) model = (model & ~m) | (d & m);
  endtask
  // Read back and compare all outputs against the model
  task automatic chk(input logic [7:0] off);
    logic nm;
    nm = capability_fuses[FVC_FUSE_NO_ME_A] | capability_fuses[FVC_FUSE_NO_ME_B];
    @(negedge clock) {cfg_rd, cfg_offset} = {1'b1, off};
    #1 `CHK(cfg_hit, off == FVC_OFFSET)
    @(negedge clock) cfg_rd = 0;
    claim_req = 4'($urandom);
    #1 `CHK(cfg_rdata, (off == FVC_OFFSET) ? model : 32'h00000000)
    `CHK(vis_o, vis(model, nm))
    `CHK(claim_ack, claim_req & vis(model, nm))
    `CHK(port6, model[13])
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    {cfg_wr, cfg_rd, txt_lock, reset_n, cfg_offset, cfg_be, cfg_wdata} = '0;
    {capability_fuses, claim_req, err_count, checks_done, cyc} = '0;
    model = FVC_RESET;
    void'($urandom(19297));
    repeat (8) @(posedge clock);
    @(negedge clock) reset_n = 1;
    chk(FVC_OFFSET);
    `CHK(vis_o, 4'hF)
    $display("Test reset done");
    // corner writes: clear, set, function 0 off, byte lane only
    wr(FVC_OFFSET, 4'hF, 32'h00000000);
    chk(FVC_OFFSET);
    wr(FVC_OFFSET, 4'hF, 32'hFFFFFFFF);
    chk(FVC_OFFSET);
    wr(FVC_OFFSET, 4'hF, 32'hFFFFFFBF);
    chk(FVC_OFFSET);
    wr(FVC_OFFSET, 4'h2, 32'h00000000);
    chk(FVC_OFFSET);
    txt_lock = 1;
    wr(FVC_OFFSET, 4'hF, 32'hFFFFFFFF);
    chk(FVC_OFFSET);
    txt_lock = 0;
    // fuses hide functions 2 and 3
    wr(FVC_OFFSET, 4'hF, 32'hFFFFFFFF);
    capability_fuses[FVC_FUSE_NO_ME_B] = 1;
    chk(FVC_OFFSET);
    capability_fuses = '0;
    capability_fuses[FVC_FUSE_NO_ME_A] = 1;
    chk(FVC_OFFSET);
    $display("Test corners done");
    // Random traffic with lock, fuses and unmapped offsets
    repeat (60) begin
      txt_lock = ($urandom % 4) == 0;
      capability_fuses = {6'h00, 2'($urandom % 3 == 0 ? $urandom : 0), 56'h0};
      wr(($urandom % 3 == 0) ? 8'($urandom & 8'hFC) : FVC_OFFSET, 4'($urandom), $urandom);
      chk(($urandom % 4 == 0) ? 8'h58 : FVC_OFFSET);
    end
    $display("Test random done");
    report_and_stop();
  end
endmodule
